//--- hw/bcm_count.sv
module bcm_count #(
   parameter int W = 64,
   parameter int CW = $clog2(W + 1)
) (
   input wire logic [W-1:0] value,
   output logic [CW-1:0] lead,
   output logic [CW-1:0] trail,
   output logic [CW-1:0] ones
);

   // ------------------------------------------------------------
   // Leading, trailing and set-bit counts
   // ------------------------------------------------------------
   always_comb begin
      lead = CW'(W);
      trail = CW'(W);
      ones = '0;
      for (int i = 0; i < W; i++) begin
         // Highest set bit wins as i rises
         if (value[i]) begin
            lead = CW'(W - 1 - i);
         end
         // Lowest set bit wins as index falls
         if (value[W-1-i]) begin
            trail = CW'(W - 1 - i);
         end
         ones = ones + CW'(value[i]);
      end
   end

endmodule : bcm_count

//--- hw/bcm_pkg.sv
// Behaviour
// - Leading zeros: width minus one minus highest set index; zero input gives width.
// - Word leading zeros count down from bit 31, ignoring higher bits.
// - Word leading zeros: 32 for zero low word, 0 when bit 31 set.
// - Population count over the full source width.
// - Word population count over bits 0 to 31 only.
// - Trailing zeros count upward from bit 0 to the first one.
// - Trailing zeros: width for zero source, 0 when bit 0 set.
// - Word trailing zeros: 32 for zero low word, 0 when bit 0 set.
// - Signed maximum of source_one and source_two.
// - Unsigned maximum of source_one and source_two.
// - Signed minimum of source_one and source_two.
// - Unsigned minimum of source_one and source_two.
// - Each result byte all ones if its source byte is nonzero, else zero.
// - Result is source_one OR the complement of source_two.
// - Optional fused absolute value: signed max of value and its negation.
package bcm_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int BCM_XLEN = 64;
   localparam int BCM_WORD = 32;
   localparam int BCM_BYTE = 8;
   localparam int BCM_OP_W = 4;
   localparam int BCM_WORD_XLEN = 64;

   // ------------------------------------------------------------
   // Operation selects
   // ------------------------------------------------------------
   typedef enum logic [BCM_OP_W-1:0] {
      BCM_OP_LZC  = 4'h0,
      BCM_OP_LZCW = 4'h1,
      BCM_OP_POP  = 4'h2,
      BCM_OP_POPW = 4'h3,
      BCM_OP_TZC  = 4'h4,
      BCM_OP_TZCW = 4'h5,
      BCM_OP_MAX  = 4'h6,
      BCM_OP_MAXU = 4'h7,
      BCM_OP_MIN  = 4'h8,
      BCM_OP_MINU = 4'h9,
      BCM_OP_ORCB = 4'hA,
      BCM_OP_ORN  = 4'hB,
      BCM_OP_ABS  = 4'hC
   } bcm_op_t;

endpackage : bcm_pkg

//--- hw/bcm_unit.sv
module bcm_unit
   import bcm_pkg::*;
#(
   parameter int XLEN = BCM_XLEN
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic op_valid,
   input wire logic [BCM_OP_W-1:0] op_sel,
   input wire logic [XLEN-1:0] lone_source,
   input wire logic [XLEN-1:0] source_one,
   input wire logic [XLEN-1:0] source_two,
   output logic result_valid,
   output logic op_illegal,
   output logic [XLEN-1:0] dest_reg
);

   localparam int CW = $clog2(XLEN + 1);
   localparam int WCW = $clog2(BCM_WORD + 1);
   localparam bit WORD_OK = (XLEN == BCM_WORD_XLEN);

   typedef struct packed {
      logic valid;
      logic illegal;
      logic [XLEN-1:0] result;
   } bcm_state_t;

   bcm_state_t state;
   bcm_state_t next_state;

   // ------------------------------------------------------------
   // Counters, full width and low word
   // ------------------------------------------------------------
   logic [CW-1:0] full_lead;
   logic [CW-1:0] full_trail;
   logic [CW-1:0] full_ones;
   logic [WCW-1:0] word_lead;
   logic [WCW-1:0] word_trail;
   logic [WCW-1:0] word_ones;

   bcm_count #(.W(XLEN), .CW(CW)) u_full (
      .value(lone_source),
      .lead(full_lead),
      .trail(full_trail),
      .ones(full_ones)
   );

   bcm_count #(.W(BCM_WORD), .CW(WCW)) u_word (
      .value(lone_source[BCM_WORD-1:0]),
      .lead(word_lead),
      .trail(word_trail),
      .ones(word_ones)
   );

   // ------------------------------------------------------------
   // Byte OR-combine
   // ------------------------------------------------------------
   logic [XLEN-1:0] byte_or;

   for (genvar b = 0; b < XLEN / BCM_BYTE; b++) begin : g_orc
      assign byte_or[b*BCM_BYTE +: BCM_BYTE] =
         {BCM_BYTE{|lone_source[b*BCM_BYTE +: BCM_BYTE]}};
   end

   // ------------------------------------------------------------
   // Compares and fused absolute value
   // ------------------------------------------------------------
   logic signed_gt;
   logic unsigned_gt;
   logic [XLEN-1:0] negated;
   logic [XLEN-1:0] abs_value;

   assign signed_gt = $signed(source_one) > $signed(source_two);
   assign unsigned_gt = source_one > source_two;
   assign negated = (~source_one) + XLEN'(1);
   // Most negative value maps to itself, as max(x, -x) does
   assign abs_value = ($signed(source_one) > $signed(negated)) ? source_one : negated;

   // ------------------------------------------------------------
   // Next result
   // ------------------------------------------------------------
   always_comb begin
      next_state.valid = op_valid;
      next_state.illegal = 1'b0;
      next_state.result = '0;
      if (op_valid) begin
         unique case (bcm_op_t'(op_sel))
            BCM_OP_LZC: begin
               next_state.result = XLEN'(full_lead);
            end
            BCM_OP_LZCW: begin
               if (WORD_OK) begin
                  next_state.result = XLEN'(word_lead);
               end else begin
                  next_state.illegal = 1'b1;
               end
            end
            BCM_OP_POP: begin
               next_state.result = XLEN'(full_ones);
            end
            BCM_OP_POPW: begin
               if (WORD_OK) begin
                  next_state.result = XLEN'(word_ones);
               end else begin
                  next_state.illegal = 1'b1;
               end
            end
            BCM_OP_TZC: begin
               next_state.result = XLEN'(full_trail);
            end
            BCM_OP_TZCW: begin
               if (WORD_OK) begin
                  next_state.result = XLEN'(word_trail);
               end else begin
                  next_state.illegal = 1'b1;
               end
            end
            BCM_OP_MAX: begin
               next_state.result = signed_gt ? source_one : source_two;
            end
            BCM_OP_MAXU: begin
               next_state.result = unsigned_gt ? source_one : source_two;
            end
            BCM_OP_MIN: begin
               next_state.result = signed_gt ? source_two : source_one;
            end
            BCM_OP_MINU: begin
               next_state.result = unsigned_gt ? source_two : source_one;
            end
            BCM_OP_ORCB: begin
               next_state.result = byte_or;
            end
            BCM_OP_ORN: begin
               next_state.result = source_one | ~source_two;
            end
            BCM_OP_ABS: begin
               next_state.result = abs_value;
            end
            default: begin
               next_state.illegal = 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Output register, frozen while clk_en is low unless reset is high
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   assign result_valid = state.valid;
   assign op_illegal = state.illegal;
   assign dest_reg = state.result;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   logic issue;
   assign issue = clk_en && op_valid;

   lz_zero_a: assert property (
      issue && op_sel == BCM_OP_LZC && lone_source == '0
      |=> dest_reg == XLEN'(XLEN) && !op_illegal)
      else $error("leading count of zero is not the width");

   lz_msb_a: assert property (
      issue && op_sel == BCM_OP_LZC && lone_source[XLEN-1]
      |=> dest_reg == '0)
      else $error("leading count with top bit set is not zero");

   lzw_low_a: assert property (
      issue && WORD_OK && op_sel == BCM_OP_LZCW
      && lone_source[BCM_WORD-1:0] == 32'h0000_0001
      |=> dest_reg == XLEN'(31))
      else $error("word leading count looks past the low word");

   lzw_ends_a: assert property (
      issue && WORD_OK && op_sel == BCM_OP_LZCW
      |=> dest_reg == ($past(lone_source[BCM_WORD-1:0]) == '0 ? XLEN'(32)
         : $past(lone_source[BCM_WORD-1]) ? XLEN'(0) : dest_reg))
      else $error("word leading count end case wrong");

   pop_full_a: assert property (
      issue && op_sel == BCM_OP_POP
      |=> dest_reg == XLEN'($countones($past(lone_source))))
      else $error("population count wrong");

   pop_word_a: assert property (
      issue && WORD_OK && op_sel == BCM_OP_POPW
      |=> dest_reg == XLEN'($countones($past(lone_source[BCM_WORD-1:0]))))
      else $error("word population count wrong");

   tz_ends_a: assert property (
      issue && op_sel == BCM_OP_TZC && (lone_source == '0 || lone_source[0])
      |=> dest_reg == ($past(lone_source[0]) ? XLEN'(0) : XLEN'(XLEN)))
      else $error("trailing count end case wrong");

   tz_scan_a: assert property (
      issue && op_sel == BCM_OP_TZC && lone_source == XLEN'(4)
      |=> dest_reg == XLEN'(2))
      else $error("trailing count does not scan upward");

   tzw_ends_a: assert property (
      issue && WORD_OK && op_sel == BCM_OP_TZCW
      && (lone_source[BCM_WORD-1:0] == '0 || lone_source[0])
      |=> dest_reg == ($past(lone_source[0]) ? XLEN'(0) : XLEN'(32)))
      else $error("word trailing count end case wrong");

   smax_a: assert property (
      issue && op_sel == BCM_OP_MAX
      |=> $signed(dest_reg) >= $signed($past(source_one))
      && $signed(dest_reg) >= $signed($past(source_two))
      && (dest_reg == $past(source_one) || dest_reg == $past(source_two)))
      else $error("signed maximum wrong");

   umax_a: assert property (
      issue && op_sel == BCM_OP_MAXU
      |=> dest_reg >= $past(source_one) && dest_reg >= $past(source_two)
      && (dest_reg == $past(source_one) || dest_reg == $past(source_two)))
      else $error("unsigned maximum wrong");

   smin_a: assert property (
      issue && op_sel == BCM_OP_MIN
      |=> $signed(dest_reg) <= $signed($past(source_one))
      && $signed(dest_reg) <= $signed($past(source_two))
      && (dest_reg == $past(source_one) || dest_reg == $past(source_two)))
      else $error("signed minimum wrong");

   umin_a: assert property (
      issue && op_sel == BCM_OP_MINU
      |=> dest_reg <= $past(source_one) && dest_reg <= $past(source_two)
      && (dest_reg == $past(source_one) || dest_reg == $past(source_two)))
      else $error("unsigned minimum wrong");

   orc_byte_a: assert property (
      issue && op_sel == BCM_OP_ORCB
      |=> dest_reg[BCM_BYTE-1:0] == {BCM_BYTE{|$past(lone_source[BCM_BYTE-1:0])}}
      && dest_reg[XLEN-1 -: BCM_BYTE] == {BCM_BYTE{|$past(lone_source[XLEN-1 -: BCM_BYTE])}})
      else $error("byte OR-combine wrong");

   orn_a: assert property (
      issue && op_sel == BCM_OP_ORN
      |=> dest_reg == ($past(source_one) | ~$past(source_two)))
      else $error("OR with inverted operand wrong");

   abs_a: assert property (
      issue && op_sel == BCM_OP_ABS && !source_one[XLEN-1]
      |=> dest_reg == $past(source_one))
      else $error("fused absolute value changes a positive value");

   word_gate_a: assert property (
      issue && (op_sel == BCM_OP_LZCW || op_sel == BCM_OP_POPW
      || op_sel == BCM_OP_TZCW)
      |=> op_illegal == !WORD_OK)
      else $error("word variant legality wrong");

   one_cycle_a: assert property (
      clk_en |=> result_valid == $past(op_valid))
      else $error("result not presented after one cycle");

   freeze_a: assert property (
      !clk_en |=> $stable(dest_reg) && $stable(result_valid) && $stable(op_illegal))
      else $error("outputs moved while clock enable low");

   lz_scan_a: assert property (
      issue && op_sel == BCM_OP_LZC && lone_source != '0
      |=> ($past(lone_source) >> (XLEN - 1 - dest_reg)) == XLEN'(1))
      else $error("leading count does not find the highest one");

   lzw_scan_a: assert property (
      issue && WORD_OK && op_sel == BCM_OP_LZCW && lone_source[BCM_WORD-1:0] != '0
      |=> ($past(lone_source[BCM_WORD-1:0]) >> (BCM_WORD - 1 - dest_reg)) == 32'h0000_0001)
      else $error("word leading count does not find the highest one");

   tz_find_a: assert property (
      issue && op_sel == BCM_OP_TZC && lone_source != '0
      |=> ($past(lone_source) << (XLEN - 1 - dest_reg)) == {1'b1, {(XLEN-1){1'b0}}})
      else $error("trailing count does not find the lowest one");

   tzw_find_a: assert property (
      issue && WORD_OK && op_sel == BCM_OP_TZCW && lone_source[BCM_WORD-1:0] != '0
      |=> ($past(lone_source[BCM_WORD-1:0]) << (BCM_WORD - 1 - dest_reg)) == 32'h8000_0000)
      else $error("word trailing count does not find the lowest one");

   idle_out_a: assert property (
      clk_en && !op_valid |=> !result_valid && !op_illegal && dest_reg == '0)
      else $error("idle cycle left a result standing");

   word_zero_a: assert property (
      issue && !WORD_OK && (op_sel == BCM_OP_LZCW || op_sel == BCM_OP_POPW
      || op_sel == BCM_OP_TZCW)
      |=> dest_reg == '0)
      else $error("unimplemented word variant returned data");

endmodule : bcm_unit

//--- tb/bcm_rf_model.sv
module bcm_rf_model
   import bcm_pkg::*;
#(
   parameter int XLEN = BCM_XLEN
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic result_valid,
   input wire logic [XLEN-1:0] dest_reg,
   output logic [15:0] wb_count,
   output logic [XLEN-1:0] wb_last
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Register file write-back port
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         wb_count <= 16'h0000;
         wb_last <= '0;
      end else if (clk_en && result_valid) begin
         wb_count <= wb_count + 16'h0001;
         wb_last <= dest_reg;
      end
   end
endmodule : bcm_rf_model

//--- tb/test_bit_count_minmax_unit.sv
module test_bit_count_minmax_unit
   import bcm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int XL = BCM_XLEN;
   localparam logic [XL-1:0] Z = 64'h0;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic op_valid = 1'b0;
   logic [BCM_OP_W-1:0] op_sel = 4'h0;
   logic [XL-1:0] ls = 64'h0;
   logic [XL-1:0] s1 = 64'h0;
   logic [XL-1:0] s2 = 64'h0;
   logic rv, il, n_rv, n_il;
   logic [XL-1:0] dr, wb_last;
   logic [31:0] n_dr;
   logic [15:0] wb_count;
   int err_total = 0;
   int samples_checked = 0;

   bcm_unit #(.XLEN(XL)) u_dut (.clk(clk), .reset(reset), .clk_en(clk_en),
      .op_valid(op_valid), .op_sel(op_sel), .lone_source(ls), .source_one(s1),
      .source_two(s2), .result_valid(rv), .op_illegal(il), .dest_reg(dr));
   // Narrow build: word counts not implemented
   bcm_unit #(.XLEN(32)) u_dut_narrow (.clk(clk), .reset(reset), .clk_en(clk_en),
      .op_valid(op_valid), .op_sel(op_sel), .lone_source(ls[31:0]),
      .source_one(s1[31:0]), .source_two(s2[31:0]), .result_valid(n_rv),
      .op_illegal(n_il), .dest_reg(n_dr));
   bcm_rf_model #(.XLEN(XL)) u_rf (.clk(clk), .reset(reset), .clk_en(clk_en),
      .result_valid(rv), .dest_reg(dr), .wb_count(wb_count), .wb_last(wb_last));

   initial begin
      forever #4 clk = ~clk;
   end

   // ----------------------------------------
   // Shared drivers and compares
   // ----------------------------------------
   task automatic chk_data(input logic [XL-1:0] exp, input logic [XL-1:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t data exp %h got %h", $time, exp, got);
      end
   endtask : chk_data

   task automatic chk_flag(input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t flag exp %b got %b", $time, exp, got);
      end
   endtask : chk_flag

   task automatic issue(input logic [3:0] op, input logic [XL-1:0] a, b, c);
      @(posedge clk);
      op_valid <= 1'b1;
      op_sel <= op;
      ls <= a;
      s1 <= b;
      s2 <= c;
      @(posedge clk);
      op_valid <= 1'b0;
      @(negedge clk);
      chk_flag(1'b1, rv);
   endtask : issue

   task automatic op_chk(input logic [3:0] op, input logic [XL-1:0] a, b, c, exp);
      issue(op, a, b, c);
      chk_flag(1'b0, il);
      chk_data(exp, dr);
   endtask : op_chk

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_lead();
      op_chk(BCM_OP_LZC, Z, Z, Z, 64'h40);
      op_chk(BCM_OP_LZC, 64'h0000_0000_0001_0000, Z, Z, 64'h2F);
      op_chk(BCM_OP_LZC, 64'hFFFF_FFFF_FFFF_FFFF, Z, Z, Z);
      op_chk(BCM_OP_LZCW, 64'hFFFF_FFFF_0000_0100, Z, Z, 64'h17);
      op_chk(BCM_OP_LZCW, 64'hFFFF_FFFF_0000_0001, Z, Z, 64'h1F);
      op_chk(BCM_OP_LZCW, 64'hFFFF_FFFF_0000_0000, Z, Z, 64'h20);
      op_chk(BCM_OP_LZCW, 64'h0000_0000_8000_0000, Z, Z, 64'h0);
      $display("leading zero test done");
   endtask : t_lead

   task automatic t_pop();
      op_chk(BCM_OP_POP, 64'hFFFF_FFFF_FFFF_FFFF, Z, Z, 64'h40);
      op_chk(BCM_OP_POP, 64'hF0F0_0000_0000_0001, Z, Z, 64'h9);
      op_chk(BCM_OP_POPW, 64'hFFFF_FFFF_0000_0003, Z, Z, 64'h2);
      $display("ones count test done");
   endtask : t_pop

   task automatic t_trail();
      op_chk(BCM_OP_TZC, Z, Z, Z, 64'h40);
      op_chk(BCM_OP_TZC, 64'hFFFF_FFFF_FFFF_FFFF, Z, Z, 64'h0);
      op_chk(BCM_OP_TZC, 64'h8000_0000_0000_0000, Z, Z, 64'h3F);
      op_chk(BCM_OP_TZC, 64'h0000_0000_0001_0000, Z, Z, 64'h10);
      op_chk(BCM_OP_TZC, 64'h0000_0000_0000_0004, Z, Z, 64'h2);
      op_chk(BCM_OP_TZCW, 64'hFFFF_FFFF_0000_0000, Z, Z, 64'h20);
      op_chk(BCM_OP_TZCW, 64'h0000_0001_8000_0000, Z, Z, 64'h1F);
      op_chk(BCM_OP_TZCW, 64'hFFFF_FFFF_FFFF_FFFF, Z, Z, 64'h0);
      $display("trailing zero test done");
   endtask : t_trail

   task automatic t_minmax();
      logic [XL-1:0] a = 64'hFFFF_FFFF_FFFF_FFFE;
      logic [XL-1:0] b = 64'h0000_0000_0000_0005;
      op_chk(BCM_OP_MAX, Z, a, b, b);
      op_chk(BCM_OP_MAXU, Z, a, b, a);
      op_chk(BCM_OP_MIN, Z, a, b, a);
      op_chk(BCM_OP_MINU, Z, a, b, b);
      $display("min max test done");
   endtask : t_minmax

   task automatic t_logic();
      op_chk(BCM_OP_ORCB, 64'h0001_0080_0000_FF10, Z, Z, 64'h00FF_00FF_0000_FFFF);
      op_chk(BCM_OP_ORN, Z, 64'h0F0F_0000_0000_0000, 64'hFFFF_0000_FFFF_0000,
         64'h0F0F_FFFF_0000_FFFF);
      op_chk(BCM_OP_ABS, Z, 64'hFFFF_FFFF_FFFF_FFFB, Z, 64'h5);
      op_chk(BCM_OP_ABS, Z, 64'h0000_0000_0000_0007, Z, 64'h7);
      op_chk(BCM_OP_ABS, Z, 64'h8000_0000_0000_0000, Z, 64'h8000_0000_0000_0000);
      $display("logic and fused test done");
   endtask : t_logic

   task automatic t_illegal();
      issue(4'hD, 64'hFFFF_FFFF_FFFF_FFFF, Z, Z);
      chk_flag(1'b1, il);
      chk_data(Z, dr);
      chk_flag(1'b1, n_rv);
      op_chk(BCM_OP_LZCW, Z, Z, Z, 64'h20);
      chk_flag(1'b1, n_il);
      chk_data(Z, {32'h0, n_dr});
      op_chk(BCM_OP_LZC, Z, Z, Z, 64'h40);
      chk_flag(1'b0, n_il);
      chk_data(64'h20, {32'h0, n_dr});
      $display("illegal op test done");
   endtask : t_illegal

   task automatic t_hold();
      logic [15:0] wb_snap;
      @(posedge clk);
      op_valid <= 1'b1;
      op_sel <= BCM_OP_ORN;
      s1 <= Z;
      s2 <= 64'h1;
      @(posedge clk);
      op_valid <= 1'b0;
      clk_en <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk_flag(1'b1, rv);
      chk_data(64'hFFFF_FFFF_FFFF_FFFE, dr);
      wb_snap = wb_count;
      @(posedge clk);
      clk_en <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk_flag(1'b0, rv);
      chk_data(Z, dr);
      chk_data(64'hFFFF_FFFF_FFFF_FFFE, wb_last);
      chk_data({48'h0, wb_snap + 16'h0001}, {48'h0, wb_count});
      $display("clock enable hold test done");
   endtask : t_hold

   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk_flag(1'b0, rv);
      chk_data(Z, dr);
      t_lead();
      t_pop();
      t_trail();
      t_minmax();
      t_logic();
      t_illegal();
      t_hold();
      end_of_test();
   end
endmodule : test_bit_count_minmax_unit
